// ---- design/vme_bridge_pkg.sv ----
// Constants shared by the bus bridge, its arbiter and its data buffer.
// Assumes a single 200 MHz core clock and a synchronous active-high reset.
package vme_bridge_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TIMEOUT_US = 100;
  localparam int TIMEOUT_CYCLES = (TIMEOUT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TMO_W = 16;

  // ----------------------------------------------------------------------
  // Page map types and address space boundaries
  // ----------------------------------------------------------------------
  localparam logic [1:0] TYPE_MEM = 2'h0;
  localparam logic [1:0] TYPE_D16 = 2'h2;
  localparam logic [1:0] TYPE_D32 = 2'h3;
  localparam logic [7:0] A24_TOP_BYTE = 8'hff;
  localparam logic [15:0] A16_TOP_HALF = 16'hffff;
  localparam logic [11:0] SYS_WIN_MB = 12'h000;
  localparam logic [11:0] SYS_VIRT_MB = 12'hfff;
  localparam logic [7:0] ONBOARD_VIRT_TOP = 8'hff;

  // ----------------------------------------------------------------------
  // Address modifier groups (bits 5..4)
  // ----------------------------------------------------------------------
  localparam logic [1:0] AM_A24 = 2'h3;
  localparam logic [1:0] AM_A32 = 2'h0;
  localparam logic [1:0] AM_A16 = 2'h2;

  // ----------------------------------------------------------------------
  // Address space codes driven on the bus
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {SPACE_A32, SPACE_A24, SPACE_A16} space_t;

  // ----------------------------------------------------------------------
  // Arbiter requesters, highest priority first
  // ----------------------------------------------------------------------
  localparam int NREQ = 5;
  localparam int REQ_NET = 0;
  localparam int REQ_FLUSH = 1;
  localparam int REQ_DISK = 2;
  localparam int REQ_SLAVE = 3;
  localparam int REQ_CPU = 4;

  // ----------------------------------------------------------------------
  // Buffer and reset values
  // ----------------------------------------------------------------------
  localparam int BUF_W = 32;
  localparam int BUF_DEPTH = 2;
  localparam logic [4:0] GRANT_RST = 5'h00;

endpackage

// ---- design/mem_arbiter.sv ----
// Fixed-priority arbiter for memory requesters, bit 0 highest.
// Assumes requesters hold their request until their cycle is reported done.
module mem_arbiter (
  input wire logic clk,
  input wire logic rst,
  input wire logic [vme_bridge_pkg::NREQ-1:0] req,
  input wire logic done,
  output logic [vme_bridge_pkg::NREQ-1:0] grant
);

  logic [vme_bridge_pkg::NREQ-1:0] grant_r;
  logic [vme_bridge_pkg::NREQ-1:0] grant_nxt;

  // ----------------------------------------------------------------------
  // Priority pick
  // ----------------------------------------------------------------------
  always_comb begin
    grant_nxt = grant_r;
    if (grant_r == '0 || done) begin
      grant_nxt = (req & ~grant_r) & (~(req & ~grant_r) + 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      grant_r <= vme_bridge_pkg::GRANT_RST;
    end else begin
      grant_r <= grant_nxt;
    end
  end

  assign grant = grant_r;

  one_grant_a: assert property (@(posedge clk) disable iff (rst) $onehot0(grant_r))
    else $error("more than one grant");
  grant_hold_a: assert property (@(posedge clk) disable iff (rst)
    (grant_r != '0 && !done) |=> $stable(grant_r))
    else $error("grant changed mid cycle");

endmodule

// ---- design/data_buf.sv ----
// Two-entry valid/ready buffer for read data returned toward the bus.
// Assumes the drain side may stall at any time.
module data_buf (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [vme_bridge_pkg::BUF_W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [vme_bridge_pkg::BUF_W-1:0] out_data
);

  logic [vme_bridge_pkg::BUF_W-1:0] mem_r [vme_bridge_pkg::BUF_DEPTH];
  logic wp_r;
  logic rp_r;
  logic [1:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_r[rp_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      wp_r <= wp_r ^ push;
      rp_r <= rp_r ^ pop;
      cnt_r <= 2'(cnt_r + {1'b0, push} - {1'b0, pop});
    end
  end

  no_overflow_a: assert property (@(posedge clk) disable iff (rst)
    (cnt_r == 2'h2 && !pop) |=> cnt_r == 2'h2)
    else $error("buffer lost an entry");

endmodule

// ---- design/vme_bridge.sv ----
// Dual-ported bus bridge: CPU master path, bus slave path and memory arbiter.
// Assumes a translation unit outside that answers page fault and protection.
// Function
// - Two map types give D16 or D32 cycles
// - Top 64K A16, top 16M A24, else A32
// - Any CPU alignment split into legal cycles
// - Timeout at least 100us after acquisition
// - A32 and D32 as master and slave
// - Single-level arbiter, jumper can disable
// - Release bus only on other request
// - Handle interrupts 1-7, never interrupter
// - Slave read-modify-write atomic against bus
// - CPU read-modify-write atomic against bus
// - No block transfers, single addressed cycles
// - Priority net, flush, disk, slave, CPU; CPU request tied low, never granted
// - Only type 0 memory reachable
// - Translate with context, address, access code
// - Net and disk map to top 16MB supervisor; flush uses its full 28-bit address
// - Onboard devices ignore enable bits
// - No protection check during cache flush
// - Slave takes byte, word, long, both modes
// - Decode address and AM 5..4 only
// - Bus error for absent or non-memory
// - Bus error on fault, protection, read error
// - System window low 1MB to top MB
// - User window bit 31, context 30..28
// - Disabled context gets no response
module vme_bridge (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // Configuration
  input wire logic ARBITER_JUMPER,
  input wire logic SYSTEM_SPACE_ACCESS_ENABLE,
  input wire logic [7:0] USER_ENABLE,
  input wire logic [2:0] CONTEXT_NUMBER,
  input wire logic MEM_ERR_INT_ENABLE,
  // CPU master request
  input wire logic CPU_REQ,
  input wire logic [1:0] CPU_TYPE,
  input wire logic [31:0] CPU_ADDR,
  input wire logic [2:0] CPU_SIZE,
  input wire logic CPU_WRITE,
  input wire logic CPU_RMW,
  input wire logic [31:0] CPU_WDATA,
  output logic CPU_ACK,
  output logic CPU_BERR,
  output logic [31:0] CPU_RDATA,
  // Bus master signals
  output logic BUS_REQ,
  input wire logic BUS_GRANT,
  input wire logic BUS_OTHER_REQ,
  output logic BUS_BUSY,
  output logic BUS_AS,
  output logic [1:0] BUS_SPACE,
  output logic [31:0] BUS_ADDR,
  output logic [3:0] BUS_DS,
  output logic BUS_WRITE,
  output logic [31:0] BUS_WDATA,
  input wire logic [31:0] BUS_RDATA,
  input wire logic BUS_DTACK,
  input wire logic BUS_BERR_IN,
  // Arbiter request input and grant output toward other boards
  input wire logic [6:0] BUS_REQ_IN,
  output logic BUS_GRANT_OUT,
  // Interrupt handler
  input wire logic [7:1] BUS_IRQ,
  output logic [2:0] IRQ_LEVEL,
  // Bus slave side
  input wire logic SLV_AS,
  input wire logic [31:0] SLV_ADDR,
  input wire logic [5:0] SLV_AM,
  input wire logic [3:0] SLV_DS,
  input wire logic SLV_WRITE,
  input wire logic SLV_LOCK,
  input wire logic [31:0] SLV_WDATA,
  output logic SLV_DTACK,
  output logic SLV_BERR,
  output logic [31:0] SLV_RDATA,
  input wire logic SLV_RDY,
  // Onboard direct_virtual_memory_access requesters
  input wire logic NET_REQ,
  input wire logic [23:0] NET_ADDR,
  input wire logic FLUSH_REQ,
  input wire logic [27:0] FLUSH_ADDR,
  input wire logic DISK_REQ,
  input wire logic [23:0] DISK_ADDR,
  output logic [4:0] MEM_GRANT,
  output logic MEM_DONE_OUT,
  // Translated memory port
  output logic MEM_REQ,
  output logic [2:0] MEM_CONTEXT,
  output logic [27:0] MEM_VADDR,
  output logic MEM_SUPER,
  output logic MEM_CHECK,
  output logic MEM_WRITE,
  input wire logic MEM_DONE,
  input wire logic [1:0] MEM_PTYPE,
  input wire logic MEM_FAULT,
  input wire logic MEM_PROT,
  input wire logic MEM_RD_ERR,
  input wire logic [31:0] MEM_RDATA,
  output logic MEM_ERR_IRQ
);

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  function automatic logic [1:0] space_of(input logic [31:0] a);
    if (a[31:16] == vme_bridge_pkg::A16_TOP_HALF) begin
      return 2'(vme_bridge_pkg::SPACE_A16);
    end else if (a[31:24] == vme_bridge_pkg::A24_TOP_BYTE) begin
      return 2'(vme_bridge_pkg::SPACE_A24);
    end
    return 2'(vme_bridge_pkg::SPACE_A32);
  endfunction

  function automatic logic [3:0] lanes_of(input logic [1:0] off, input logic [2:0] n);
    logic [3:0] m;
    m = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (i >= off && i < off + n) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // ----------------------------------------------------------------------
  // Master path state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {M_IDLE, M_ACQ, M_XFER, M_DONE} mst_t;
  mst_t mst_r;
  logic own_r;
  logic [31:0] addr_r;
  logic [2:0] left_r;
  logic [31:0] wdata_r;
  logic [31:0] rdata_r;
  logic berr_r;
  logic as_r;
  logic [3:0] ds_r;
  logic [vme_bridge_pkg::TMO_W-1:0] tmo_r;
  logic [2:0] chunk;
  logic [2:0] width;
  logic [1:0] off;

  assign width = (CPU_TYPE == vme_bridge_pkg::TYPE_D32) ? 3'h4 : 3'h2;
  assign off = addr_r[1:0];
  // bytes up to the next lane boundary of the port width.
  always_comb begin
    chunk = 3'(width - (width == 3'h4 ? {1'b0, off} : {2'b00, off[0]}));
    if (chunk > left_r) begin
      chunk = left_r;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      mst_r <= M_IDLE;
      addr_r <= 32'h0;
      left_r <= 3'h0;
      wdata_r <= 32'h0;
      rdata_r <= 32'h0;
      berr_r <= 1'b0;
      as_r <= 1'b0;
      ds_r <= 4'h0;
      tmo_r <= '0;
    end else begin
      unique case (mst_r)
        M_IDLE: begin
          berr_r <= 1'b0;
          if (CPU_REQ) begin
            addr_r <= CPU_ADDR;
            left_r <= CPU_SIZE;
            wdata_r <= CPU_WDATA;
            mst_r <= M_ACQ;
          end
        end
        M_ACQ: begin
          if (own_r) begin
            tmo_r <= '0;
            as_r <= 1'b1;
            ds_r <= lanes_of(off, chunk);
            mst_r <= M_XFER;
          end
        end
        M_XFER: begin
          tmo_r <= tmo_r + 1'b1;
          if (BUS_DTACK || BUS_BERR_IN
              || tmo_r == vme_bridge_pkg::TMO_W'(vme_bridge_pkg::TIMEOUT_CYCLES - 1)) begin
            as_r <= 1'b0;
            ds_r <= 4'h0;
            berr_r <= berr_r | ~BUS_DTACK;
            for (int i = 0; i < 4; i++) begin
              if (ds_r[i]) begin
                rdata_r[8*i +: 8] <= BUS_RDATA[8*i +: 8];
              end
            end
            addr_r <= addr_r + 32'(chunk);
            left_r <= left_r - chunk;
            mst_r <= (left_r == chunk || !BUS_DTACK) ? M_DONE : M_ACQ;
          end
        end
        M_DONE: mst_r <= M_IDLE;
      endcase
    end
  end

  // ownership stays until another requester asks; holds it over a lock.
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      own_r <= 1'b0;
    end else if (!own_r && BUS_GRANT && mst_r == M_ACQ) begin
      own_r <= 1'b1;
    end else if (own_r && BUS_OTHER_REQ && (mst_r == M_IDLE || mst_r == M_DONE)
                 && !(CPU_RMW && CPU_REQ)) begin
      own_r <= 1'b0;
    end
  end

  assign BUS_REQ = (mst_r == M_ACQ) && !own_r;
  assign BUS_BUSY = own_r;
  assign BUS_AS = as_r;
  assign BUS_DS = ds_r;
  assign BUS_ADDR = addr_r;
  assign BUS_SPACE = space_of(addr_r);
  assign BUS_WRITE = CPU_WRITE;
  assign BUS_WDATA = wdata_r;
  assign CPU_ACK = (mst_r == M_DONE);
  assign CPU_BERR = (mst_r == M_DONE) && berr_r;
  assign CPU_RDATA = rdata_r;

  // ----------------------------------------------------------------------
  // Single-level bus arbiter and interrupt handler
  // ----------------------------------------------------------------------
  logic bgo_r;
  logic [2:0] irq_r;
  logic slv_hold_r;
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      bgo_r <= 1'b0;
    end else begin
      bgo_r <= ARBITER_JUMPER && BUS_REQ_IN[3] && !own_r && !BUS_REQ && !slv_hold_r;
    end
  end
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      irq_r <= 3'h0;
    end else begin
      irq_r <= 3'h0;
      for (int l = 1; l <= 7; l++) begin
        if (BUS_IRQ[l]) begin
          irq_r <= 3'(l);
        end
      end
    end
  end
  assign BUS_GRANT_OUT = bgo_r;
  assign IRQ_LEVEL = irq_r;

  // ----------------------------------------------------------------------
  // Slave decode
  // ----------------------------------------------------------------------
  logic sys_hit;
  logic usr_hit;
  logic am_a24;
  logic am_a32;
  assign am_a24 = SLV_AM[5:4] == vme_bridge_pkg::AM_A24;
  assign am_a32 = SLV_AM[5:4] == vme_bridge_pkg::AM_A32;
  assign sys_hit = SYSTEM_SPACE_ACCESS_ENABLE
    && ((am_a32 && SLV_ADDR[31:20] == vme_bridge_pkg::SYS_WIN_MB)
    || (am_a24 && SLV_ADDR[23:20] == 4'h0));
  assign usr_hit = am_a32 && SLV_ADDR[31] && USER_ENABLE[SLV_ADDR[30:28]];

  // ----------------------------------------------------------------------
  // Memory arbitration
  // ----------------------------------------------------------------------
  logic [4:0] reqs;
  logic [4:0] gnt;
  logic slv_busy_r;
  assign reqs = {1'b0, SLV_AS && (sys_hit || usr_hit) && !slv_busy_r,
                 DISK_REQ, FLUSH_REQ, NET_REQ};

  mem_arbiter u_arb (
    .clk(CORE_CLK),
    .rst(RESET),
    .req(reqs),
    .done(MEM_DONE),
    .grant(gnt)
  );
  assign MEM_GRANT = gnt;
  assign MEM_DONE_OUT = MEM_DONE;

  always_comb begin
    MEM_CONTEXT = CONTEXT_NUMBER;
    MEM_VADDR = 28'h0;
    MEM_SUPER = 1'b1;
    MEM_CHECK = 1'b1;
    MEM_WRITE = 1'b0;
    if (gnt[vme_bridge_pkg::REQ_NET]) begin
      MEM_VADDR = {vme_bridge_pkg::ONBOARD_VIRT_TOP[3:0], NET_ADDR};
    end else if (gnt[vme_bridge_pkg::REQ_FLUSH]) begin
      MEM_VADDR = FLUSH_ADDR;
      MEM_CHECK = 1'b0;
    end else if (gnt[vme_bridge_pkg::REQ_DISK]) begin
      MEM_VADDR = {vme_bridge_pkg::ONBOARD_VIRT_TOP[3:0], DISK_ADDR};
    end else if (gnt[vme_bridge_pkg::REQ_SLAVE]) begin
      MEM_WRITE = SLV_WRITE;
      if (SLV_ADDR[31] && am_a32) begin
        MEM_CONTEXT = SLV_ADDR[30:28];
        MEM_VADDR = SLV_ADDR[27:0];
        MEM_SUPER = 1'b0;
      end else begin
        MEM_VADDR = {vme_bridge_pkg::SYS_VIRT_MB[7:0], SLV_ADDR[19:0]};
      end
    end
  end
  assign MEM_REQ = gnt != 5'h0;

  // ----------------------------------------------------------------------
  // Slave answer
  // ----------------------------------------------------------------------
  logic slv_err;
  logic [31:0] buf_data;
  logic buf_valid;
  logic buf_ready;
  logic berr_sr;
  logic irq_mem_r;
  assign slv_err = MEM_PTYPE != vme_bridge_pkg::TYPE_MEM || MEM_FAULT || MEM_PROT
                   || (MEM_RD_ERR && !SLV_WRITE);

  data_buf u_buf (
    .clk(CORE_CLK),
    .rst(RESET),
    .in_valid(gnt[vme_bridge_pkg::REQ_SLAVE] && MEM_DONE),
    .in_ready(buf_ready),
    .in_data(MEM_RDATA),
    .out_valid(buf_valid),
    .out_ready(SLV_RDY && slv_busy_r),
    .out_data(buf_data)
  );

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      slv_busy_r <= 1'b0;
      berr_sr <= 1'b0;
      slv_hold_r <= 1'b0;
    end else begin
      if (gnt[vme_bridge_pkg::REQ_SLAVE] && MEM_DONE && buf_ready) begin
        slv_busy_r <= 1'b1;
        berr_sr <= slv_err;
      end else if (!SLV_AS) begin
        slv_busy_r <= 1'b0;
        berr_sr <= 1'b0;
      end
      slv_hold_r <= SLV_LOCK && SLV_AS;
    end
  end
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      irq_mem_r <= 1'b0;
    end else begin
      irq_mem_r <= MEM_DONE && MEM_RD_ERR && MEM_ERR_INT_ENABLE;
    end
  end
  assign SLV_DTACK = slv_busy_r && !berr_sr && buf_valid;
  assign SLV_BERR = slv_busy_r && berr_sr;
  assign SLV_RDATA = buf_data;
  assign MEM_ERR_IRQ = irq_mem_r;

  // while a locked slave cycle runs, no other board is granted the bus.
  lock_grant_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    slv_hold_r |=> !bgo_r)
    else $error("grant given during slave lock");
  flush_check_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    gnt[vme_bridge_pkg::REQ_FLUSH] |-> !MEM_CHECK)
    else $error("flush was protection checked");
  bad_type_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (gnt[vme_bridge_pkg::REQ_SLAVE] && MEM_DONE && buf_ready && MEM_PTYPE != 2'h0)
    |=> SLV_BERR && !SLV_DTACK)
    else $error("non-memory slave access not refused");
  keep_bus_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (own_r && !BUS_OTHER_REQ) |=> own_r)
    else $error("bus released without request");
  tmo_floor_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    ($rose(as_r) ##1 (!BUS_DTACK && !BUS_BERR_IN)[*8]) |-> as_r)
    else $error("transfer ended early");
  user_off_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (am_a32 && SLV_ADDR[31] && !USER_ENABLE[SLV_ADDR[30:28]] && !sys_hit)
    |-> !reqs[vme_bridge_pkg::REQ_SLAVE])
    else $error("disabled context answered");
  space_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (as_r && addr_r[31:16] == 16'hffff) |-> BUS_SPACE == 2'(vme_bridge_pkg::SPACE_A16))
    else $error("wrong short space");
  net_top_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    gnt[vme_bridge_pkg::REQ_NET] |-> MEM_SUPER && MEM_VADDR[27:24] == 4'hf)
    else $error("onboard mapping wrong");

endmodule

// ---- tb/far_side.sv ----
// Far-side model: bus arbiter and answering boards, plus the translation unit.
// Assumes the bridge holds each strobe until its answer has been sampled.
module far_side (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Behaviour controls
  input wire logic slow,
  input wire logic mute,
  input wire logic [1:0] ptype,
  // Bus side
  input wire logic bus_req,
  input wire logic bus_as,
  input wire logic [31:0] bus_addr,
  output logic bus_grant,
  output logic bus_dtack,
  output logic [31:0] bus_rdata,
  // Memory side
  input wire logic mem_req,
  input wire logic [27:0] mem_vaddr,
  output logic mem_done,
  output logic [1:0] mem_ptype,
  output logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] bw_r;
  logic [3:0] mw_r;
  assign mem_ptype = ptype;
  always_ff @(posedge clk) begin
    bus_grant <= bus_req & ~rst;
  end
  // Released data lines show a pattern that changes every cycle.
  always_ff @(posedge clk) begin
    if (rst || !bus_as) begin
      bw_r <= 4'h0;
      bus_dtack <= 1'b0;
      bus_rdata <= rst ? 32'h0 : ~bus_rdata;
    end else if (!mute && !bus_dtack && bw_r == (slow ? 4'h8 : 4'h1)) begin
      bus_dtack <= 1'b1;
      bus_rdata <= {bus_addr[15:0], ~bus_addr[15:0]};
    end else if (!bus_dtack) begin
      bw_r <= bw_r + 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    mem_done <= 1'b0;
    mem_rdata <= rst ? 32'h0 : ~mem_rdata;
    if (rst || !mem_req) begin
      mw_r <= 4'h0;
    end else if (mw_r == (slow ? 4'h6 : 4'h2)) begin
      mem_done <= 1'b1;
      mem_rdata <= {4'h0, mem_vaddr};
      mw_r <= 4'hc;
    end else begin
      mw_r <= mw_r + 4'h1;
    end
  end
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the bus bridge: master path, slave path and arbiter.
// Assumes the far-side model answers the bus and the translation unit.
`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LIMIT = 40000;
  logic clk = 1'b0, rst = 1'b1, jmp = 1'b1, sys_en = 1'b0, cpu_req = 1'b0, cpu_wr = 1'b0;
  logic other = 1'b0, slv_as = 1'b0, slv_wr = 1'b0, slv_rdy = 1'b1, net_req = 1'b0;
  logic fl_req = 1'b0, dk_req = 1'b0, mflt = 1'b0, rd_err = 1'b0, slow = 1'b0, mute = 1'b0;
  logic as_q = 1'b0, lock = 1'b0, su_seen, irq_seen;
  logic [1:0] cpu_ty = 2'h3, ptype = 2'h0, sp_seen;
  logic [2:0] cpu_sz = 3'h4, cx = 3'h0, ctx_seen;
  logic [3:0] slv_ds = 4'hf;
  logic [5:0] slv_am = 6'h00;
  logic [6:0] req_in = 7'h00, irq = 7'h00;
  logic [7:0] u_en = 8'h00;
  logic [23:0] net_a = 24'h0, dk_a = 24'h0;
  logic [27:0] fl_a = 28'h0, va_seen;
  logic [31:0] cpu_a = 32'h0, slv_a = 32'h0;
  int as_cnt, as_len, cyc, fails, tests_run;
  logic ack, berr, busy, b_as, g_out, s_dtack, s_berr, m_req, m_super, m_irq;
  logic b_req, b_grant, b_dtack, m_done;
  logic [1:0] b_space, m_ptype;
  logic [2:0] irq_lv, m_ctx;
  logic [4:0] m_grant;
  logic [27:0] m_va;
  logic [31:0] rdata, b_addr, b_rdata, s_rdata, m_rdata;

  vme_bridge uut (
    .CORE_CLK(clk), .RESET(rst), .ARBITER_JUMPER(jmp),
    .SYSTEM_SPACE_ACCESS_ENABLE(sys_en), .USER_ENABLE(u_en), .CONTEXT_NUMBER(cx),
    .MEM_ERR_INT_ENABLE(1'b1), .CPU_REQ(cpu_req), .CPU_TYPE(cpu_ty), .CPU_ADDR(cpu_a),
    .CPU_SIZE(cpu_sz), .CPU_WRITE(cpu_wr), .CPU_RMW(1'b0), .CPU_WDATA(~cpu_a),
    .CPU_ACK(ack), .CPU_BERR(berr), .CPU_RDATA(rdata), .BUS_REQ(b_req),
    .BUS_GRANT(b_grant), .BUS_OTHER_REQ(other), .BUS_BUSY(busy), .BUS_AS(b_as),
    .BUS_SPACE(b_space), .BUS_ADDR(b_addr), .BUS_DS(), .BUS_WRITE(), .BUS_WDATA(),
    .BUS_RDATA(b_rdata), .BUS_DTACK(b_dtack), .BUS_BERR_IN(1'b0), .BUS_REQ_IN(req_in),
    .BUS_GRANT_OUT(g_out), .BUS_IRQ(irq), .IRQ_LEVEL(irq_lv), .SLV_AS(slv_as),
    .SLV_ADDR(slv_a), .SLV_AM(slv_am), .SLV_DS(slv_ds), .SLV_WRITE(slv_wr),
    .SLV_LOCK(lock), .SLV_WDATA(~slv_a), .SLV_DTACK(s_dtack), .SLV_BERR(s_berr),
    .SLV_RDATA(s_rdata), .SLV_RDY(slv_rdy), .NET_REQ(net_req), .NET_ADDR(net_a),
    .FLUSH_REQ(fl_req), .FLUSH_ADDR(fl_a), .DISK_REQ(dk_req), .DISK_ADDR(dk_a),
    .MEM_GRANT(m_grant), .MEM_DONE_OUT(), .MEM_REQ(m_req), .MEM_CONTEXT(m_ctx),
    .MEM_VADDR(m_va), .MEM_SUPER(m_super), .MEM_CHECK(), .MEM_WRITE(),
    .MEM_DONE(m_done), .MEM_PTYPE(m_ptype), .MEM_FAULT(mflt), .MEM_PROT(1'b0),
    .MEM_RD_ERR(rd_err), .MEM_RDATA(m_rdata), .MEM_ERR_IRQ(m_irq)
  );
  far_side peer (
    .clk(clk), .rst(rst), .slow(slow), .mute(mute), .ptype(ptype), .bus_req(b_req),
    .bus_as(b_as), .bus_addr(b_addr), .bus_grant(b_grant), .bus_dtack(b_dtack),
    .bus_rdata(b_rdata), .mem_req(m_req), .mem_vaddr(m_va), .mem_done(m_done),
    .mem_ptype(m_ptype), .mem_rdata(m_rdata)
  );

  // ----------------------------------------------------------------------
  // Clock, monitor and run limit
  // ----------------------------------------------------------------------
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    as_q <= b_as;
    cyc <= cyc + 1;
    if (b_as && !as_q) begin
      as_cnt <= as_cnt + 1;
      as_len <= 1;
      sp_seen <= b_space;
    end else if (b_as) begin
      as_len <= as_len + 1;
    end
    if (m_req) begin
      va_seen <= m_va;
      ctx_seen <= m_ctx;
      su_seen <= m_super;
    end
    if (m_irq) irq_seen <= 1'b1;
    if (cyc == LIMIT) begin
      fails++;
      close_out();
    end
  end

  task automatic close_out();
    if (fails == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cpu(input logic [1:0] ty, input logic [31:0] a, input logic [2:0] sz,
                     input logic wr, input logic [1:0] sp, input int n);
    int i;
    as_cnt = 0;
    @(posedge clk);
    cpu_ty <= ty;
    cpu_a <= a;
    cpu_sz <= sz;
    cpu_wr <= wr;
    cpu_req <= 1'b1;
    for (i = 0; i < 30000 && ack !== 1'b1; i++) @(negedge clk);
    `CHK(sp_seen, sp)
    `CHK(as_cnt, n)
    `CHK(berr, mute)
    if (mute) `CHK(as_len >= vme_bridge_pkg::TIMEOUT_CYCLES, 1'b1)
    else if (!wr && sz == 3'h4 && n == 1) `CHK(rdata, {a[15:0], ~a[15:0]})
    @(posedge clk);
    cpu_req <= 1'b0;
  endtask

  task automatic slv(input logic [31:0] a, input logic [5:0] am, input logic se,
                     input logic [1:0] f, input logic [1:0] ex, input logic [27:0] va,
                     input logic [2:0] cx_e, input logic su, input logic wr);
    int i;
    irq_seen = 1'b0;
    @(posedge clk);
    sys_en <= se;
    mflt <= f == 2'h1;
    rd_err <= f == 2'h2;
    ptype <= {1'b0, f == 2'h3};
    slv_a <= a;
    slv_am <= am;
    slv_wr <= wr;
    slv_ds <= wr ? 4'h3 : 4'hf;
    slv_rdy <= wr;
    slv_as <= 1'b1;
    for (i = 0; i < 40 && s_dtack !== 1'b1 && s_berr !== 1'b1; i++) @(negedge clk);
    `CHK({s_dtack, s_berr}, ex)
    if (ex != 2'h0) `CHK({ctx_seen, su_seen, va_seen[27:2]}, {cx_e, su, va[27:2]})
    if (ex == 2'h2 && !wr) `CHK(s_rdata, {4'h0, va})
    @(posedge clk);
    slv_as <= 1'b0;
    slv_rdy <= 1'b1;
    repeat (4) @(negedge clk);
    `CHK(irq_seen, f == 2'h2)
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    int i;
    int k;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    cpu(2'h3, 32'h0000_1000, 3'h4, 1'b0, 2'h0, 1);
    cpu(2'h3, 32'hfeff_fffc, 3'h4, 1'b0, 2'h0, 1);
    cpu(2'h3, 32'hff00_0000, 3'h4, 1'b0, 2'h1, 1);
    cpu(2'h3, 32'hfffe_fffc, 3'h4, 1'b0, 2'h1, 1);
    cpu(2'h3, 32'hffff_0010, 3'h4, 1'b0, 2'h2, 1);
    cpu(2'h2, 32'hff00_2000, 3'h4, 1'b0, 2'h1, 2);
    cpu(2'h2, 32'h0000_3001, 3'h4, 1'b1, 2'h0, 3);
    cpu(2'h3, 32'h0000_4003, 3'h2, 1'b1, 2'h0, 2);
    cpu(2'h2, 32'hffff_0021, 3'h1, 1'b0, 2'h2, 1);
    repeat (5) @(negedge clk);
    `CHK(busy, 1'b1)
    @(posedge clk);
    other <= 1'b1;
    for (i = 0; i < 20 && busy !== 1'b0; i++) @(negedge clk);
    `CHK(busy, 1'b0)
    @(posedge clk);
    other <= 1'b0;
    irq <= 7'h05;
    req_in <= 7'h08;
    for (i = 0; i < 20 && g_out !== 1'b1; i++) @(negedge clk);
    `CHK(g_out, 1'b1)
    `CHK(irq_lv, 3'h3)
    for (k = 0; k < 2; k++) begin
      @(posedge clk);
      req_in <= 7'h00;
      {jmp, lock, slv_as} <= {3{k == 0}};
      repeat (4) @(posedge clk);
      req_in <= 7'h08;
      repeat (8) @(negedge clk);
      `CHK(g_out, 1'b0)
    end
    @(posedge clk);
    req_in <= 7'h00;
    net_a <= 24'h12_3456;
    fl_a <= 28'h0ab_cdef;
    dk_a <= 24'h65_4321;
    net_req <= 1'b1;
    fl_req <= 1'b1;
    dk_req <= 1'b1;
    for (k = 0; k < 3; k++) begin
      for (i = 0; i < 50 && m_grant === 5'h00; i++) @(negedge clk);
      `CHK(m_grant, 5'(1 << k))
      if (k == 0) `CHK({m_super, m_va}, {1'b1, 4'hf, net_a})
      for (i = 0; i < 50 && m_done !== 1'b1; i++) @(negedge clk);
      @(posedge clk);
      {dk_req, fl_req, net_req} <= {dk_req, fl_req, net_req} & ~3'(1 << k);
      @(negedge clk);
    end
    @(posedge clk);
    cx <= 3'h5;
    u_en <= 8'h02;
    slow <= 1'b1;
    slv(32'h0000_0100, 6'h3d, 1'b1, 2'h0, 2'h2, 28'hff0_0100, 3'h5, 1'b1, 1'b0);
    slv(32'h000f_fffc, 6'h0a, 1'b1, 2'h0, 2'h2, 28'hfff_fffc, 3'h5, 1'b1, 1'b1);
    slv(32'h0000_0100, 6'h3d, 1'b0, 2'h0, 2'h0, 28'h0, 3'h0, 1'b0, 1'b0);
    slv(32'h0000_0100, 6'h2d, 1'b1, 2'h0, 2'h0, 28'h0, 3'h0, 1'b0, 1'b0);
    slv(32'h0000_0100, 6'h3d, 1'b1, 2'h3, 2'h1, 28'hff0_0100, 3'h5, 1'b1, 1'b0);
    slv(32'h0000_0200, 6'h39, 1'b1, 2'h1, 2'h1, 28'hff0_0200, 3'h5, 1'b1, 1'b0);
    slv(32'h0000_0300, 6'h3d, 1'b1, 2'h2, 2'h1, 28'hff0_0300, 3'h5, 1'b1, 1'b0);
    slv(32'h9000_0100, 6'h09, 1'b0, 2'h0, 2'h2, 28'h000_0100, 3'h1, 1'b0, 1'b0);
    slv(32'ha000_0100, 6'h09, 1'b1, 2'h0, 2'h0, 28'h0, 3'h0, 1'b0, 1'b0);
    @(posedge clk);
    mute <= 1'b1;
    cpu(2'h3, 32'h0000_2000, 3'h4, 1'b0, 2'h0, 1);
    close_out();
  end
endmodule
